// >>> design/udi_defs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef UDI_DEFS_SVH
`define UDI_DEFS_SVH
// register offsets on the parallel register port
`define UDI_MODE_OFS 8'h0C
`define UDI_CFG_OFS 8'h10
`define UDI_EN_OFS 8'h14
// mode register: global enable position
`define UDI_GEN_BIT 3
// configuration register fields
`define UDI_CTRL_LSB 6
`define UDI_IN_LSB 4
`define UDI_OUT_LSB 2
`define UDI_LVL_BIT 1
`define UDI_POL_BIT 0
`define UDI_CFG_RST 8'hFC
`define UDI_POLICY_BRST 6'h3F
// enable mask: implemented bits and source positions
`define UDI_EN_IMPL 32'h03FF_FD7F
`define UDI_EN_RST 32'h0000_0000
`define UDI_EP0_IN_BIT 11
`define UDI_EP0_OUT_BIT 10
`define UDI_EP1_BIT 12
`define UDI_SETUP_BIT 8
// pulse timing
`define UDI_CLK_NS 8
`define UDI_PULSE_NS 60
`define UDI_PULSE_CYC ((`UDI_PULSE_NS + `UDI_CLK_NS - 1) / `UDI_CLK_NS)
`endif

// >>> design/udi_pkg.sv
// Purpose: types shared by the interrupt control files
// Assumes: nothing
// Notes: constants live in udi_defs.svh
package udi_pkg;
    // handshake kinds seen or sent by the serial engine
    typedef enum logic [1:0] {
        UDI_HS_ACK = 2'h0,
        UDI_HS_NAK = 2'h1,
        UDI_HS_STALL = 2'h2,
        UDI_HS_NYET = 2'h3
    } udi_hs_kind_t;
    // one handshake event
    typedef struct packed {
        logic valid; // one-cycle strobe
        logic [2:0] ep; // endpoint number
        logic dir_in; // 1 = in (tx), 0 = out (rx) or setup
        udi_hs_kind_t kind; // handshake kind
    } udi_hs_evt_t;
    // bus event pulses
    typedef struct packed {
        logic setup_rx;
        logic dma_change;
        logic speed_change;
        logic resume;
        logic suspend;
        logic pseudo_frame;
        logic frame_start;
        logic bus_reset;
    } udi_bus_evt_t;
    // register access request
    typedef struct packed {
        logic wr; // write strobe
        logic rd; // read strobe
        logic [7:0] addr; // byte offset
        logic [31:0] wdata; // write data
    } udi_reg_req_t;
    // pin stage states
    typedef enum logic [1:0] {
        UDI_PIN_IDLE = 2'b01,
        UDI_PIN_PULSE = 2'b10
    } udi_pin_state_t;
    // pin stage state
    typedef struct packed {
        udi_pin_state_t state;
        logic [7:0] cnt;
        logic pin;
    } udi_pin_st_t;
    // controller state
    typedef struct packed {
        logic [31:0] mask;
        logic [7:0] cfg;
        logic gen;
        logic [31:0] pend;
        logic [15:0] armed;
        logic [31:0] rdata;
        logic trig;
        logic lvl;
    } udi_ctrl_st_t;
endpackage : udi_pkg

// >>> design/udi_irq_pin.sv
// Purpose: drives the interrupt pin in level or pulsed form
// Assumes: trig_i is a one-cycle pulse per interrupt
// Notes: pin output comes straight from a flip-flop
`include "udi_defs.svh"
module udi_irq_pin #(
    parameter int PULSE_CYC = `UDI_PULSE_CYC
) (
    input wire logic core_clk_i, // core clock
    input wire logic sys_rst_i, // async reset, active high
    input wire logic trig_i, // new enabled interrupt
    input wire logic lvl_i, // level request
    input wire logic pulse_sel_i, // 1 = pulsed signalling
    input wire logic pol_i, // 1 = active high
    output logic irq_o // interrupt pin
);
    // counter holds at most 255
    if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_chk
        $error("pulse length out of range");
    end

    udi_pkg::udi_pin_st_t q, n;
    logic act;

    // next state: pulse sequencer and pin sense
    always_comb begin
        n = q;
        act = 1'b0;
        case (q.state)
            udi_pkg::UDI_PIN_IDLE: begin
                // R1: start pulse
                if (pulse_sel_i && trig_i) begin
                    n.state = udi_pkg::UDI_PIN_PULSE;
                    n.cnt = 8'(PULSE_CYC - 1);
                end
            end
            udi_pkg::UDI_PIN_PULSE: begin
                if (q.cnt == 8'h00) begin
                    n.state = udi_pkg::UDI_PIN_IDLE;
                end else begin
                    n.cnt = q.cnt - 8'h01;
                end
            end
            default: begin
                n.state = udi_pkg::UDI_PIN_IDLE;
            end
        endcase
        // R1: level or pulse
        act = pulse_sel_i ? (n.state == udi_pkg::UDI_PIN_PULSE) : lvl_i;
        // R2: polarity applied
        n.pin = pol_i ? act : ~act;
    end

    // state register
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '{state: udi_pkg::UDI_PIN_IDLE, cnt: 8'h00, pin: 1'b1};
        end else begin
            q <= n;
        end
    end

    assign irq_o = q.pin;

    // R1: pulse width check
    // cycles since a pulse was launched, zero while no pulse is watched
    logic [8:0] wid_q;
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wid_q <= 9'h000;
        end else if (trig_i && pulse_sel_i && q.state == udi_pkg::UDI_PIN_IDLE) begin
            wid_q <= 9'h001;
        end else if (wid_q == 9'(PULSE_CYC + 1)) begin
            wid_q <= 9'h000;
        end else if (wid_q != 9'h000) begin
            wid_q <= wid_q + 9'h001;
        end
    end

    // pin active for exactly PULSE_CYC cycles, then released
    property p_pulse_len;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (wid_q != 9'h000 && $past(pulse_sel_i))
            |-> ((wid_q <= 9'(PULSE_CYC)) == (irq_o == $past(pol_i)));
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse width wrong"); // R1

    // R2: level follows request
    property p_level_out;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (!pulse_sel_i) |=> (irq_o == ($past(pol_i) ? $past(lvl_i) : !$past(lvl_i)));
    endproperty
    a_level_out: assert property (p_level_out) else $error("level pin wrong"); // R2

    c_pulse: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
        q.state == udi_pkg::UDI_PIN_PULSE ##1 q.state == udi_pkg::UDI_PIN_IDLE);
endmodule // udi_irq_pin

// >>> design/udi_irq_ctrl.sv
// Purpose: interrupt policy, enable mask and request logic of a usb device
// Assumes: engine events are one-cycle pulses on core_clk_i
// Notes: pending bits are cleared by pend_clr_i from the status side
//
// Notes on behaviour
// R1: level holds output, pulse gives 60 ns
// R2: polarity bit sets sense, kept on bus reset
// R3: control policy selects ack, stall, nak triggers
// R4: in policy selects ack and nak triggers
// R5: out policy selects ack, stall, nyet, nak
// R6: first nak only after an ack
// R7: handshakes raise interrupts, filtered by policy
// R8: in uses in policy, out uses out
// R9: endpoint 0 always uses control policy
// R10: bits 25..12 enable data endpoints
// R11: bit 11 control in, 10 control out
// R12: bit 8 enables setup received, 9 reserved
// R13: bit 6 enables dma status change
// R14: bit 5 enables speed status change
// R15: bit 4 resume, bit 3 suspend
// R16: bits 2..0 pseudo frame, frame, bus reset
// R17: global enable off blocks every source
// R18: bus reset clears mask except bit 0
// R19: processor writes zeros to bits 31..26
// R20: mask is 32 bits, rw, reset zero
// R21: global enable mode bit 3, kept
// R22: output active when enabled source pending
`include "udi_defs.svh"
module udi_irq_ctrl #(
    parameter int PULSE_CYC = `UDI_PULSE_CYC
) (
    input wire logic core_clk_i, // 125 MHz core clock
    input wire logic sys_rst_i, // async reset, active high
    input wire udi_pkg::udi_reg_req_t reg_req_i, // register access
    output logic [31:0] reg_rdata_o, // read data, one cycle after read
    input wire udi_pkg::udi_hs_evt_t hs_evt_i, // handshake event
    input wire udi_pkg::udi_bus_evt_t bus_evt_i, // bus event pulses
    input wire logic [31:0] pend_clr_i, // clear pending bits
    output logic [31:0] pend_o, // pending sources
    output logic irq_o // interrupt pin
);
    // pin stage counts fit in eight bits
    if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_chk
        $error("pulse length out of range");
    end

    udi_pkg::udi_ctrl_st_t q, n; // state and next state
    logic [31:0] set_v; // sources raised this cycle

    // mask position of a handshake source
    function automatic logic [4:0] src_bit(input logic [2:0] ep, input logic dir_in);
        logic [4:0] b;
        b = 5'd0;
        if (ep == 3'd0) begin
            // R11: control in and out bits
            b = dir_in ? 5'(`UDI_EP0_IN_BIT) : 5'(`UDI_EP0_OUT_BIT);
        end else begin
            // R10: tx above rx
            b = 5'(`UDI_EP1_BIT) + {1'b0, ep - 3'd1, dir_in};
        end
        return b;
    endfunction

    // policy filter for one handshake
    function automatic logic hs_pass(input logic [1:0] pol, input udi_pkg::udi_hs_kind_t k,
                                     input logic stall_ok, input logic nyet_ok,
                                     input logic armed);
        logic r;
        r = 1'b0;
        case (k)
            udi_pkg::UDI_HS_ACK: r = 1'b1;
            udi_pkg::UDI_HS_STALL: r = stall_ok;
            udi_pkg::UDI_HS_NYET: r = nyet_ok;
            udi_pkg::UDI_HS_NAK: begin
                // R6: first nak only
                if (pol[1]) begin
                    r = armed;
                end else begin
                    r = (pol == 2'b00);
                end
            end
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // next state
    always_comb begin
        logic [1:0] pol;
        logic stall_ok;
        logic nyet_ok;
        logic [3:0] idx;
        logic [31:0] rd;
        n = q;
        pol = 2'b00;
        stall_ok = 1'b0;
        nyet_ok = 1'b0;
        idx = {hs_evt_i.ep, hs_evt_i.dir_in};
        rd = 32'h0000_0000;
        set_v = 32'h0000_0000;

        // R9: endpoint 0 control policy
        if (hs_evt_i.ep == 3'd0) begin
            // R3: control triggers
            pol = q.cfg[`UDI_CTRL_LSB +: 2];
            stall_ok = 1'b1;
        end else if (hs_evt_i.dir_in) begin
            // R4: in triggers, R8 tx side
            pol = q.cfg[`UDI_IN_LSB +: 2];
        end else begin
            // R5: out triggers, R8 rx side
            pol = q.cfg[`UDI_OUT_LSB +: 2];
            stall_ok = 1'b1;
            nyet_ok = 1'b1;
        end

        // R7: handshake raises source
        if (hs_evt_i.valid) begin
            if (hs_pass(pol, hs_evt_i.kind, stall_ok, nyet_ok, q.armed[idx])) begin
                set_v[src_bit(hs_evt_i.ep, hs_evt_i.dir_in)] = 1'b1;
            end
            // R6: ack rearms first nak
            if (hs_evt_i.kind == udi_pkg::UDI_HS_ACK) begin
                n.armed[idx] = 1'b1;
            end else if (hs_evt_i.kind == udi_pkg::UDI_HS_NAK) begin
                n.armed[idx] = 1'b0;
            end
        end

        // R12: setup received source
        set_v[`UDI_SETUP_BIT] = bus_evt_i.setup_rx;
        // R13: R14: R15: R16: bus sources
        set_v[6:0] = {bus_evt_i.dma_change, bus_evt_i.speed_change, bus_evt_i.resume,
                      bus_evt_i.suspend, bus_evt_i.pseudo_frame, bus_evt_i.frame_start,
                      bus_evt_i.bus_reset};

        // pending: set wins over clear
        n.pend = ((q.pend & ~pend_clr_i) | set_v) & `UDI_EN_IMPL;

        // register writes
        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                `UDI_MODE_OFS: begin
                    // R21: global enable write
                    n.gen = reg_req_i.wdata[`UDI_GEN_BIT];
                end
                `UDI_CFG_OFS: begin
                    n.cfg = reg_req_i.wdata[7:0];
                end
                `UDI_EN_OFS: begin
                    // R20: R19: reserved bits dropped
                    n.mask = reg_req_i.wdata & `UDI_EN_IMPL;
                end
                default: begin
                    // unmapped write ignored
                end
            endcase
        end

        // R18: bus reset clears mask
        if (bus_evt_i.bus_reset) begin
            n.mask = {31'h0000_0000, n.mask[0]};
            // R2: polarity and mode kept, policies back to 11
            n.cfg[7:2] = `UDI_POLICY_BRST;
        end

        // register reads
        case (reg_req_i.addr)
            `UDI_MODE_OFS: rd[`UDI_GEN_BIT] = q.gen;
            `UDI_CFG_OFS: rd[7:0] = q.cfg;
            `UDI_EN_OFS: rd = q.mask;
            default: rd = 32'h0000_0000;
        endcase
        if (reg_req_i.rd) begin
            n.rdata = rd;
        end

        // R17: global gate, R1 pulse per new interrupt
        n.trig = q.gen && ((set_v & q.mask) != 32'h0000_0000);
        // R22: level request
        n.lvl = n.gen && ((n.pend & n.mask) != 32'h0000_0000);
    end

    // state register
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '{mask: `UDI_EN_RST, cfg: `UDI_CFG_RST, gen: 1'b0,
                   pend: 32'h0000_0000, armed: 16'h0000, rdata: 32'h0000_0000,
                   trig: 1'b0, lvl: 1'b0};
        end else begin
            q <= n;
        end
    end

    assign reg_rdata_o = q.rdata;
    assign pend_o = q.pend;

    // R1: R2: pin stage
    udi_irq_pin #(
        .PULSE_CYC(PULSE_CYC)
    ) u_pin (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .trig_i(q.trig),
        .lvl_i(q.lvl),
        .pulse_sel_i(q.cfg[`UDI_LVL_BIT]),
        .pol_i(q.cfg[`UDI_POL_BIT]),
        .irq_o(irq_o)
    );

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    // R20: reserved mask bits stay zero
    property p_mask_rsvd;
        (q.mask & ~`UDI_EN_IMPL) == 32'h0000_0000;
    endproperty
    a_mask_rsvd: assert property (p_mask_rsvd) else $error("reserved mask bit set"); // R20

    // R18: bus reset clears mask but bit 0
    property p_brst_mask;
        (bus_evt_i.bus_reset && !reg_req_i.wr)
            |=> (q.mask[31:1] == 31'h0000_0000) && (q.mask[0] == $past(q.mask[0]));
    endproperty
    a_brst_mask: assert property (p_brst_mask) else $error("bus reset mask wrong"); // R18

    // R21: global enable kept across bus reset
    property p_brst_gen;
        (bus_evt_i.bus_reset && !reg_req_i.wr) |=> q.gen == $past(q.gen);
    endproperty
    a_brst_gen: assert property (p_brst_gen) else $error("global enable lost"); // R21

    // R2: signalling bits kept, policies reloaded
    property p_brst_cfg;
        (bus_evt_i.bus_reset && !reg_req_i.wr)
            |=> (q.cfg[7:2] == 6'h3F) && (q.cfg[1:0] == $past(q.cfg[1:0]));
    endproperty
    a_brst_cfg: assert property (p_brst_cfg) else $error("bus reset config wrong"); // R2

    // R17: no request while globally disabled
    property p_global_off;
        !q.gen |=> !q.trig ##0 (!q.lvl || q.gen);
    endproperty
    a_global_off: assert property (p_global_off) else $error("request while disabled"); // R17

    // R3: policy 01 drops control nak
    property p_ctrl_nak;
        (hs_evt_i.valid && hs_evt_i.ep == 3'd0 && hs_evt_i.dir_in
         && hs_evt_i.kind == udi_pkg::UDI_HS_NAK && q.cfg[7:6] == 2'b01
         && !q.pend[11] && !bus_evt_i.setup_rx) |=> !q.pend[11];
    endproperty
    a_ctrl_nak: assert property (p_ctrl_nak) else $error("control nak raised"); // R3

    // R4: in endpoint stall never raises
    property p_in_stall;
        (hs_evt_i.valid && hs_evt_i.ep == 3'd3 && hs_evt_i.dir_in
         && hs_evt_i.kind == udi_pkg::UDI_HS_STALL && !q.pend[17]) |=> !q.pend[17];
    endproperty
    a_in_stall: assert property (p_in_stall) else $error("in stall raised"); // R4

    // R7: out ack sets pending one edge on
    property p_out_ack;
        (hs_evt_i.valid && hs_evt_i.ep == 3'd1 && !hs_evt_i.dir_in
         && hs_evt_i.kind == udi_pkg::UDI_HS_ACK) |=> q.pend[12] && q.armed[2];
    endproperty
    a_out_ack: assert property (p_out_ack) else $error("out ack not pending"); // R7

    // R6: second nak after first is silent
    property p_first_nak;
        (hs_evt_i.valid && hs_evt_i.ep == 3'd2 && !hs_evt_i.dir_in
         && hs_evt_i.kind == udi_pkg::UDI_HS_NAK && q.cfg[3] && !q.armed[4])
            |=> !q.armed[4] && (!q.pend[14] || $past(q.pend[14]));
    endproperty
    a_first_nak: assert property (p_first_nak) else $error("repeat nak raised"); // R6

    c_trig: cover property (q.trig ##1 q.lvl);
    c_brst: cover property (bus_evt_i.bus_reset && q.mask != 32'h0000_0000);
    c_nak: cover property (hs_evt_i.valid && hs_evt_i.kind == udi_pkg::UDI_HS_NAK && q.cfg[3]);
endmodule // udi_irq_ctrl

// >>> sim/udi_mcu_model.sv
// Purpose: external processor model that watches the interrupt pin
// Assumes: pol_i carries the sense the bench programmed into the device
// Notes: counts activations and the length of the last active run
module udi_mcu_model (
    input wire logic core_clk_i, // core clock
    input wire logic sys_rst_i, // async reset, active high
    input wire logic irq_i, // interrupt pin
    input wire logic pol_i, // 1 = active high
    output logic active_o, // pin active now
    output logic [7:0] edge_cnt_o, // activations seen
    output logic [7:0] last_len_o // cycles of the last active run
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] run_q; // cycles active so far
    logic was_q; // pin active at the previous edge
    // pin decoded with the programmed sense; unknown never counts as active
    // sense decode
    assign active_o = (irq_i === pol_i);
    // count activations and measure how long each one lasts
    // pulse width seen
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            run_q <= 8'h00;
            was_q <= 1'b0;
            edge_cnt_o <= 8'h00;
            last_len_o <= 8'h00;
        end else begin
            was_q <= active_o;
            // a new activation starts a fresh run
            if (active_o && !was_q) begin
                edge_cnt_o <= edge_cnt_o + 8'h01;
            end
            // run grows while active, is stored when it ends
            if (active_o) begin
                run_q <= run_q + 8'h01;
            end else begin
                run_q <= 8'h00;
                if (was_q) begin
                    last_len_o <= run_q;
                end
            end
        end
    end
endmodule // udi_mcu_model

// >>> sim/testbench.sv
// Purpose: self-checking bench for the interrupt control block
// Assumes: requests are driven by non-blocking assignment at rising edges
// Notes: a short pulse count keeps pulsed mode quick to observe
`include "udi_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PCYC = 3; // shortened pulse length in cycles
    logic core_clk_i = 1'b0; // core clock
    logic sys_rst_i; // reset, active high
    udi_pkg::udi_reg_req_t req; // register request
    udi_pkg::udi_hs_evt_t hs_evt; // handshake event
    udi_pkg::udi_bus_evt_t bus_evt; // bus event pulses
    logic [31:0] pend_clr; // pending clear
    logic [31:0] reg_rdata_o; // read data
    logic [31:0] pend_o; // pending sources
    logic irq_o; // interrupt pin
    logic pol; // sense told to the processor model
    logic act; // pin active per model
    logic [7:0] edge_cnt; // activations per model
    logic [7:0] last_len; // last run length per model
    logic [7:0] e0; // activation count before a pulse
    logic [1:0] pc, pi, po; // policy codes in use
    logic [1:0] p; // policy of the class under test
    logic arm; // first nak tracker in the bench
    logic hit; // expected pending outcome
    int n_fail = 0; // mismatches
    int n_checks = 0; // comparisons
    int cls_ep[4] = '{0, 0, 3, 2}; // endpoint per class row
    int cls_in[4] = '{1, 0, 1, 0}; // direction per class row
    int cls_bit[4] = '{11, 10, 17, 14}; // pending bit per class row
    int cls_k[4] = '{0, 0, 1, 2}; // 0 control, 1 in, 2 out
    int kseq[7] = '{0, 1, 1, 2, 3, 0, 1}; // ack nak nak stall nyet ack nak
    // 125 MHz core clock
    always #4 core_clk_i = ~core_clk_i;
    // device under test
    udi_irq_ctrl #(.PULSE_CYC(PCYC)) u_dut (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(req),
        .reg_rdata_o(reg_rdata_o), .hs_evt_i(hs_evt), .bus_evt_i(bus_evt),
        .pend_clr_i(pend_clr), .pend_o(pend_o), .irq_o(irq_o));
    // processor on the far side of the pin
    udi_mcu_model u_mcu (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .irq_i(irq_o), .pol_i(pol),
        .active_o(act), .edge_cnt_o(edge_cnt), .last_len_o(last_len));
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // counts, verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // let n edges pass, then settle
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // register write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk_i);
        req <= '0;
    endtask
    // register read and compare
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk_i);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge core_clk_i);
        req <= '0;
        tick(1);
        check(reg_rdata_o, e);
    endtask
    // one handshake from the serial engine
    task automatic hs(input logic [2:0] ep, input logic din, input logic [1:0] k);
        @(posedge core_clk_i);
        hs_evt <= '{valid: 1'b1, ep: ep, dir_in: din, kind: udi_pkg::udi_hs_kind_t'(k)};
        @(posedge core_clk_i);
        hs_evt <= '0;
        tick(1);
    endtask
    // one bus event pulse
    task automatic bev(input logic [7:0] b);
        @(posedge core_clk_i);
        bus_evt <= b;
        @(posedge core_clk_i);
        bus_evt <= '0;
        tick(1);
    endtask
    // clear every pending bit
    task automatic clr();
        @(posedge core_clk_i);
        pend_clr <= 32'hFFFF_FFFF;
        @(posedge core_clk_i);
        pend_clr <= 32'h0000_0000;
    endtask
    // guard against a hang
    initial begin
        #100000;
        n_fail++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        stop_test();
    end
    // main sequence
    initial begin
        sys_rst_i = 1'b1;
        req = '0;
        hs_evt = '0;
        bus_evt = '0;
        pend_clr = 32'h0000_0000;
        pol = 1'b0;
        repeat (2) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        tick(1);
        check({31'h0, irq_o}, 32'h1);
        rd_chk(`UDI_EN_OFS, 32'h0000_0000);
        rd_chk(`UDI_CFG_OFS, 32'h0000_00FC);
        rd_chk(`UDI_MODE_OFS, 32'h0000_0000);
        wr(8'h30, 32'hFFFF_FFFF);
        rd_chk(8'h30, 32'h0000_0000);
        // reserved top bits written as zero
        // zeros on top
        wr(`UDI_EN_OFS, 32'h03FF_FFFF);
        rd_chk(`UDI_EN_OFS, 32'h03FF_FD7F);
        $display("test registers done");
        // three of the four policy codes on every class, fields set apart from each other
        for (int j = 0; j < 3; j++) begin
            pc = (j == 2) ? {1'b1, 1'b0} : j[1:0];
            pi = (j == 1) ? 2'h3 : 2'((j + 1) % 3);
            po = (j == 0) ? 2'h2 : 2'((j + 2) % 3);
            wr(`UDI_CFG_OFS, {24'h0, pc, pi, po, 2'h0});
            for (int c = 0; c < 4; c++) begin
                p = (cls_k[c] == 0) ? pc : ((cls_k[c] == 1) ? pi : po);
                arm = 1'b0;
                for (int i = 0; i < 7; i++) begin
                    case (kseq[i])
                        0: hit = 1'b1;
                        1: hit = (p == 2'h0) ? 1'b1 : (p[1] & arm);
                        2: hit = (cls_k[c] != 1);
                        default: hit = (cls_k[c] == 2);
                    endcase
                    arm = (kseq[i] == 0) ? 1'b1 : ((kseq[i] == 1) ? 1'b0 : arm);
                    clr();
                    hs(3'(cls_ep[c]), 1'(cls_in[c]), 2'(kseq[i]));
                    check(pend_o, hit ? (32'h1 << cls_bit[c]) : 32'h0);
                end
            end
        end
        $display("test policies done");
        wr(`UDI_EN_OFS, 32'h0000_1000);
        wr(`UDI_CFG_OFS, 32'h0000_0000);
        wr(`UDI_MODE_OFS, 32'h0000_0008);
        clr();
        hs(3'h1, 1'b0, 2'h0);
        tick(2);
        check({31'h0, act}, 32'h1);
        wr(`UDI_MODE_OFS, 32'h0000_0000);
        tick(3);
        check({31'h0, act}, 32'h0);
        wr(`UDI_MODE_OFS, 32'h0000_0008);
        wr(`UDI_CFG_OFS, 32'h0000_0001);
        pol <= 1'b1;
        tick(3);
        check({31'h0, irq_o}, 32'h1);
        clr();
        tick(3);
        check({31'h0, act}, 32'h0);
        wr(`UDI_CFG_OFS, 32'h0000_0003);
        tick(3);
        e0 = edge_cnt;
        hs(3'h1, 1'b0, 2'h0);
        tick(10);
        check({24'h0, edge_cnt}, {24'h0, e0 + 8'h01});
        check({24'h0, last_len}, PCYC);
        $display("test pin done");
        // bus events land on their own pending bits
        for (int i = 7; i > 0; i--) begin
            clr();
            bev(8'h01 << i);
            check(pend_o, 32'h1 << ((i == 7) ? 8 : i));
        end
        wr(`UDI_CFG_OFS, 32'h0000_0000);
        pol <= 1'b0;
        wr(`UDI_EN_OFS, 32'h0000_0010);
        clr();
        bev(8'h08);
        tick(2);
        check({31'h0, act}, 32'h0);
        bev(8'h10);
        tick(2);
        check({31'h0, act}, 32'h1);
        $display("test bus events done");
        wr(`UDI_EN_OFS, 32'h03FF_FFFF);
        wr(`UDI_CFG_OFS, 32'h0000_0003);
        clr();
        bev(8'h01);
        check(pend_o, 32'h0000_0001);
        rd_chk(`UDI_EN_OFS, 32'h0000_0001);
        rd_chk(`UDI_CFG_OFS, 32'h0000_00FF);
        rd_chk(`UDI_MODE_OFS, 32'h0000_0008);
        $display("test bus reset done");
        stop_test();
    end
endmodule // testbench
